// ===== spp_pkg.sv
// Shared constants and types for the serial peripheral port pin logic
package spp_pkg;

	// -------------------------------------------------------------
	// Port control word field positions
	// -------------------------------------------------------------
	localparam int CTL_W          = 16;
	localparam int CTL_MASTER_POS = 0;
	localparam int CTL_CPOL_POS   = 1;
	localparam int CTL_CPHA_POS   = 2;
	localparam int CTL_OPD_POS    = 3;
	localparam int CTL_EN_POS     = 4;
	localparam int CTL_SLAVE_OUT_DISABLE_POS  = 5;

	// -------------------------------------------------------------
	// Boot straps, timing and input filtering
	// -------------------------------------------------------------
	localparam logic [1:0] BOOT_SPI_MASTER = 2'h1;
	localparam int CLK_PERIOD_NS  = 8;
	localparam int MIN_HALF_CYC   = 4;
	localparam int FILT_STAGES    = 3;
	localparam int LAST_FLAG      = 3;

	// -------------------------------------------------------------
	// Master engine states
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_SHIFT = 3'h2,
		ST_DONE  = 3'h4
	} spp_state_t;

endpackage : spp_pkg

// ===== spp_slave_link.sv
// Slave shifter running on the serial clock taken from the external master
`timescale 1ns/1ns
module spp_slave_link
	import spp_pkg::*;
#(
	parameter int WORD_BITS = 8
) (
	// Link clock and clears
	input  wire logic                 link_clk,
	input  wire logic                 sel_inactive,
	input  wire logic                 link_rst,
	// Serial data
	input  wire logic                 mosi_in,
	output logic                      miso_bit,
	// Words to and from the core domain
	input  wire logic [WORD_BITS-1:0] tx_word,
	output logic [WORD_BITS-1:0]      rx_word,
	output logic                      word_toggle
);
	localparam int CNT_W = $clog2(WORD_BITS);

	typedef struct packed {
		logic [CNT_W-1:0]     bit_cnt;
		logic [WORD_BITS-1:0] rx_sh;
	} spp_frame_t;

	typedef struct packed {
		logic [WORD_BITS-1:0] word;
		logic                 toggle;
	} spp_word_t;

	spp_frame_t       frame_reg, frame_next;
	spp_word_t        word_reg, word_next;
	logic [CNT_W-1:0] idx_reg;
	logic             last_bit;

	assign last_bit = (frame_reg.bit_cnt == CNT_W'(WORD_BITS - 1));

	// Sample on the sampling edge, flag each whole word by a toggle
	always_comb begin
		frame_next = frame_reg;
		word_next  = word_reg;
		frame_next.rx_sh = {frame_reg.rx_sh[WORD_BITS-2:0], mosi_in};
		if (last_bit) begin
			frame_next.bit_cnt = '0;
			word_next.word     = frame_next.rx_sh;
			word_next.toggle   = ~word_reg.toggle;
		end else begin
			frame_next.bit_cnt = frame_reg.bit_cnt + CNT_W'(1);
		end
	end

	// Deselect holds the count at zero and ignores clock activity
	always_ff @(posedge link_clk or posedge sel_inactive) begin
		if (sel_inactive) begin
			frame_reg <= '0;
		end else begin
			frame_reg <= frame_next;
		end
	end

	// Finished word and its toggle survive deselection
	always_ff @(posedge link_clk or posedge link_rst) begin
		if (link_rst) begin
			word_reg <= '0;
		end else begin
			word_reg <= word_next;
		end
	end

	// Launch on the opposite edge from sampling
	always_ff @(negedge link_clk or posedge sel_inactive) begin
		if (sel_inactive) begin
			idx_reg <= '0;
		end else begin
			idx_reg <= frame_reg.bit_cnt;
		end
	end

	assign miso_bit    = tx_word[CNT_W'(WORD_BITS - 1) - idx_reg];
	assign rx_word     = word_reg.word;
	assign word_toggle = word_reg.toggle;

endmodule : spp_slave_link

// ===== spp_port.sv
// Serial peripheral port: master engine, slave link, pin drivers
`timescale 1ns/1ns
module spp_port
	import spp_pkg::*;
#(
	parameter int WORD_BITS = 8,
	parameter int DIV_W     = 8,
	parameter int FLAGS     = 4
) (
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	// Configuration
	input  wire logic [CTL_W-1:0]     port_control_reg,
	input  wire logic [DIV_W-1:0]     baud_div,
	input  wire logic [1:0]           boot_mode_pins,
	input  wire logic                 boot_release,
	input  wire logic                 mm_err_clear,
	// General flags
	input  wire logic [FLAGS-1:0]     flag_select_en,
	input  wire logic [FLAGS-1:0]     flag_out_val,
	input  wire logic [FLAGS-1:0]     flag_out_en,
	// Master requests
	input  wire logic                 start,
	input  wire logic [WORD_BITS-1:0] tx_data,
	output logic                      busy,
	output logic [WORD_BITS-1:0]      rx_data,
	output logic                      rx_done,
	// Slave words
	input  wire logic [WORD_BITS-1:0] slave_tx_data,
	output logic [WORD_BITS-1:0]      slave_rx_data,
	output logic                      slave_rx_done,
	// Status
	output logic                      multimaster_err,
	output logic                      boot_active,
	// Serial clock pin
	input  wire logic                 serial_clock_in,
	output logic                      serial_clock_out,
	output logic                      serial_clock_oe_n,
	// Select and data pins
	input  wire logic                 slave_select_in,
	input  wire logic                 mosi_in,
	output logic                      mosi_out,
	output logic                      mosi_oe_n,
	input  wire logic                 miso_in,
	output logic                      miso_out,
	output logic                      miso_oe_n,
	// Flag pins
	output logic [FLAGS-1:0]          general_flag_out,
	output logic [FLAGS-1:0]          general_flag_oe_n
);
	localparam int CNT_W = $clog2(WORD_BITS);
	localparam int DC_W  = DIV_W + $clog2(MIN_HALF_CYC);
	// Half period is four core cycles per divider step plus four;
	// the divider counter carries two extra bits for that scaling

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (WORD_BITS < 2) begin : g_bad_word
		$error("WORD_BITS must be at least 2");
	end
	if (DIV_W < 1 || FLAGS <= LAST_FLAG - 3 || FLAGS < 1) begin : g_bad_div
		$error("DIV_W and FLAGS must be at least 1");
	end
	if (MIN_HALF_CYC != 4) begin : g_bad_half
		$error("half period scaling assumes four cycles");
	end

	// ------------------------------------------------------------
	// Limits
	// ------------------------------------------------------------
	// The slave link runs from the pin clock; the core must run well
	// above the link bit rate for the toggle crossing to see each word
	// An error abort drops the partial receive word without a pulse

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		spp_state_t                 state;
		logic [DC_W-1:0]            div_cnt;
		logic                       half;
		logic [CNT_W-1:0]           bit_cnt;
		logic [WORD_BITS-1:0]       tx_sh;
		logic [WORD_BITS-1:0]       rx_sh;
		logic                       mosi_bit;
		logic                       sclk_lvl;
		logic [WORD_BITS-1:0]       rx_word;
		logic                       done;
		logic                       mm_err;
		logic [FILT_STAGES-1:0]     s_miso;
		logic [FILT_STAGES-1:0]     s_ssel;
		logic [FILT_STAGES-1:0]     s_tog;
		logic                       miso_f;
		logic                       ssel_f;
		logic                       tog_f;
		logic [WORD_BITS-1:0]       slave_rx;
		logic                       slave_done;
		logic [WORD_BITS-1:0]       slave_tx;
		logic                       boot_act;
		logic                       master_q;
		logic                       slave_en_q;
	} spp_core_t;

	spp_core_t            core_reg, core_next;
	logic                 eff_master;
	logic                 eff_cpol;
	logic                 cpha;
	logic                 half_end;
	logic                 launch_ok;
	logic [DC_W-1:0]      half_last;
	logic                 link_clk;
	logic                 sel_inactive;
	logic                 link_miso;
	logic [WORD_BITS-1:0] link_rx_word;
	logic                 link_toggle;
	logic                 select_n;
	logic                 slave_drive;
	logic                 od;

	// Idle decode shared by the select flags and the busy status
	function automatic logic is_idle(input spp_state_t s);
		is_idle = (s == ST_IDLE);
	endfunction : is_idle

	// Accept a new filtered level once stages two and three agree
	function automatic logic filt(input logic [FILT_STAGES-1:0] s, input logic cur);
		filt = (s[1] == s[2]) ? s[2] : cur;
	endfunction : filt

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	// Boot forces master mode with the clock idling high
	assign eff_master = port_control_reg[CTL_MASTER_POS] | core_reg.boot_act;
	assign eff_cpol   = port_control_reg[CTL_CPOL_POS] | core_reg.boot_act;
	assign cpha       = port_control_reg[CTL_CPHA_POS];
	assign od         = port_control_reg[CTL_OPD_POS];
	// Half bit lasts four cycles per step of the divider plus four
	assign half_last  = DC_W'({baud_div, 2'b11});
	assign half_end   = (core_reg.div_cnt == half_last);
	assign launch_ok  = port_control_reg[CTL_EN_POS] & eff_master;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		core_next = core_reg;
		core_next.done       = 1'b0;
		core_next.slave_done = 1'b0;
		core_next.master_q   = eff_master;
		core_next.slave_en_q = port_control_reg[CTL_EN_POS] & ~eff_master;
		// Pin and crossing filters, first stage feeds only the second
		core_next.s_miso = {core_reg.s_miso[1:0], miso_in};
		core_next.s_ssel = {core_reg.s_ssel[1:0], slave_select_in};
		core_next.s_tog  = {core_reg.s_tog[1:0], link_toggle};
		core_next.miso_f = filt(core_reg.s_miso, core_reg.miso_f);
		core_next.ssel_f = filt(core_reg.s_ssel, core_reg.ssel_f);
		core_next.tog_f  = filt(core_reg.s_tog, core_reg.tog_f);

		// Master transfer engine
		case (core_reg.state)
			ST_IDLE: begin
				if (start && launch_ok) begin
					core_next.state   = ST_SHIFT;
					core_next.div_cnt = '0;
					core_next.half    = 1'b0;
					core_next.bit_cnt = '0;
					core_next.tx_sh   = tx_data;
					// Phase zero shows the first bit before the first edge
					if (!cpha) begin
						core_next.mosi_bit = tx_data[WORD_BITS-1];
						core_next.tx_sh    = {tx_data[WORD_BITS-2:0], 1'b0};
					end
				end
			end
			ST_SHIFT: begin
				core_next.div_cnt = core_reg.div_cnt + DC_W'(1);
				if (half_end) begin
					core_next.div_cnt = '0;
					if (!core_reg.half) begin
						// Phase one launches here, phase zero samples here
						// Leading edge
						core_next.half = 1'b1;
						if (cpha) begin
							core_next.mosi_bit = core_reg.tx_sh[WORD_BITS-1];
							core_next.tx_sh    = {core_reg.tx_sh[WORD_BITS-2:0], 1'b0};
						end else begin
							core_next.rx_sh = {core_reg.rx_sh[WORD_BITS-2:0], core_reg.miso_f};
						end
					end else begin
						// Trailing edge closes one bit
						core_next.half = 1'b0;
						if (cpha) begin
							core_next.rx_sh = {core_reg.rx_sh[WORD_BITS-2:0], core_reg.miso_f};
						end
						if (core_reg.bit_cnt == CNT_W'(WORD_BITS - 1)) begin
							core_next.state = ST_DONE;
						end else begin
							core_next.bit_cnt = core_reg.bit_cnt + CNT_W'(1);
							if (!cpha) begin
								core_next.mosi_bit = core_reg.tx_sh[WORD_BITS-1];
								core_next.tx_sh    = {core_reg.tx_sh[WORD_BITS-2:0], 1'b0};
							end
						end
					end
				end
			end
			ST_DONE: begin
				core_next.rx_word = core_reg.rx_sh;
				core_next.done    = 1'b1;
				core_next.state   = ST_IDLE;
			end
			default: begin
				core_next.state = ST_IDLE;
			end
		endcase

		// Boot ignores the select pin, which may float while the
		// boot memory is being read
		// Another master pulled our select low: flag and abort
		if (mm_err_clear) begin
			core_next.mm_err = 1'b0;
		end
		if (core_reg.master_q && !core_reg.boot_act && !core_reg.ssel_f) begin
			core_next.mm_err = 1'b1;
			core_next.state  = ST_IDLE;
		end

		// Serial clock sits at idle level outside a word
		// Next state is used so the idle level returns with the last edge
		core_next.sclk_lvl = eff_cpol ^ ((core_next.state == ST_SHIFT) & core_next.half);

		// Slave words cross by toggle; take the next reply when idle
		// The link reads the reply raw, so it only changes between words
		if (core_reg.tog_f != core_next.tog_f) begin
			core_next.slave_rx   = link_rx_word;
			core_next.slave_done = 1'b1;
			core_next.slave_tx   = slave_tx_data;
		end else if (core_reg.ssel_f) begin
			core_next.slave_tx = slave_tx_data;
		end

		if (boot_release) begin
			core_next.boot_act = 1'b0;
		end

		// Synchronous reset; boot strap is caught while held
		if (sys_rst) begin
			core_next          = '0;
			core_next.state    = ST_IDLE;
			// Select filter starts high so no false error follows release
			core_next.s_ssel   = '1;
			core_next.ssel_f   = 1'b1;
			core_next.boot_act = (boot_mode_pins == BOOT_SPI_MASTER);
			core_next.master_q = core_next.boot_act;
			core_next.sclk_lvl = core_next.boot_act;
			core_next.mosi_bit = 1'b0;
		end
	end

	// Register the whole state
	always_ff @(posedge clock) begin
		core_reg <= core_next;
	end

	// ------------------------------------------------------------
	// Slave link on the external serial clock
	// ------------------------------------------------------------
	// The select pin clears the link asynchronously, so a partial
	// word never survives into the next selection
	// Normalised so that sampling is always the rising edge
	assign link_clk     = serial_clock_in ^ port_control_reg[CTL_CPOL_POS] ^ cpha;
	assign sel_inactive = slave_select_in | ~core_reg.slave_en_q;

	spp_slave_link #(
		.WORD_BITS (WORD_BITS)
	) u_link (
		.link_clk     (link_clk),
		.sel_inactive (sel_inactive),
		.link_rst     (sys_rst),
		.mosi_in      (mosi_in),
		.miso_bit     (link_miso),
		.tx_word      (core_reg.slave_tx),
		.rx_word      (link_rx_word),
		.word_toggle  (link_toggle)
	);

	// ------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------
	// Master drives clock and MOSI; boot drives them through reset
	assign serial_clock_out  = core_reg.sclk_lvl;
	assign serial_clock_oe_n = ~core_reg.master_q;
	assign mosi_out          = core_reg.mosi_bit;
	assign mosi_oe_n         = ~core_reg.master_q;

	// Slave drives MISO only when selected and not disabled
	assign slave_drive = core_reg.slave_en_q & ~core_reg.ssel_f
		& ~port_control_reg[CTL_SLAVE_OUT_DISABLE_POS];
	// Open drain releases the pin for ones and leaves the high
	// level to the pull-up
	assign miso_out    = od ? 1'b0 : link_miso;
	assign miso_oe_n   = ~(slave_drive & (~od | ~link_miso));

	// Flags either carry software levels or act as slave select
	assign select_n = is_idle(core_reg.state);
	for (genvar i = 0; i < FLAGS; i++) begin : g_flag
		logic as_select;
		assign as_select = flag_select_en[i] | ((i == 0) & core_reg.boot_act);
		assign general_flag_out[i]  = as_select ? select_n : flag_out_val[i];
		assign general_flag_oe_n[i] = as_select ? 1'b0 : ~flag_out_en[i];
	end

	// ------------------------------------------------------------
	// Status and results
	// ------------------------------------------------------------
	// Busy spans the whole word including the result cycle
	assign busy            = ~is_idle(core_reg.state);
	assign rx_data         = core_reg.rx_word;
	assign rx_done         = core_reg.done;
	assign slave_rx_data   = core_reg.slave_rx;
	assign slave_rx_done   = core_reg.slave_done;
	assign multimaster_err = core_reg.mm_err;
	assign boot_active     = core_reg.boot_act;

endmodule : spp_port

// ===== spp_port_chk.sv
// Concurrent checks on the serial port pins
`timescale 1ns/1ns
module spp_port_chk
	import spp_pkg::*;
#(
	parameter int WORD_BITS = 8,
	parameter int DIV_W     = 8
) (
	// Clock and configuration
	input wire logic             clock,
	input wire logic             sys_rst,
	input wire logic [CTL_W-1:0] port_control_reg,
	input wire logic [DIV_W-1:0] baud_div,
	// Status and pins
	input wire logic             busy,
	input wire logic             rx_done,
	input wire logic             slave_rx_done,
	input wire logic             multimaster_err,
	input wire logic             boot_active,
	input wire logic             serial_clock_out,
	input wire logic             serial_clock_oe_n,
	input wire logic             slave_select_in,
	input wire logic             mosi_out,
	input wire logic             mosi_oe_n,
	input wire logic             miso_out,
	input wire logic             miso_oe_n
);
	// ----------------------------------------
	// Serial clock edge and half bit counters
	// ----------------------------------------
	logic        sclk_reg;
	logic [7:0]  edge_reg;
	logic [15:0] gap_reg;
	logic        chg;
	assign chg = serial_clock_out != sclk_reg;
	// Count edges within a word and cycles between edges
	always_ff @(posedge clock) begin
		sclk_reg <= serial_clock_out;
		gap_reg  <= chg ? 16'h1 : gap_reg + 16'h1;
		edge_reg <= (sys_rst || !busy) ? 8'h0 : edge_reg + {7'h0, chg};
	end
	default clocking cb @(posedge clock);
	endclocking
	boot_drive_a: assert property (
		sys_rst && $past(sys_rst) && boot_active |-> serial_clock_out && !serial_clock_oe_n
		&& !mosi_out && !mosi_oe_n) else $error("boot pins not driven");
	mm_set_a: assert property (disable iff (sys_rst)
		$fell(slave_select_in) && port_control_reg[0] && !boot_active
		##1 !slave_select_in [*5] |-> multimaster_err) else $error("no multimaster error");
	sclk_idle_a: assert property (disable iff (sys_rst)
		!busy && !$past(busy) && !$past(sys_rst) && !$past(sys_rst, 2) && !multimaster_err
		&& port_control_reg == $past(port_control_reg, 2) && boot_active == $past(boot_active, 2)
		|-> $stable(serial_clock_out)) else $error("clock moved while idle");
	clk_edges_a: assert property (disable iff (sys_rst)
		rx_done |-> edge_reg == 8'(2 * WORD_BITS)) else $error("wrong clock count");
	half_bit_a: assert property (disable iff (sys_rst)
		busy && chg && edge_reg != 8'h0 |-> gap_reg == 16'(baud_div) * 16'h4 + 16'h4)
		else $error("wrong half bit time");
	od_drive_a: assert property (disable iff (sys_rst)
		port_control_reg[3] && !miso_oe_n |-> !miso_out) else $error("open drain drove high");
	slave_out_disable_off_a: assert property (disable iff (sys_rst)
		port_control_reg[5] && !boot_active && $stable(port_control_reg) |-> miso_oe_n)
		else $error("disabled output driven");
	deselect_a: assert property (disable iff (sys_rst)
		slave_select_in [*8] |-> miso_oe_n && !slave_rx_done) else $error("idle slave active");
endmodule : spp_port_chk

bind spp_port spp_port_chk #(.WORD_BITS(WORD_BITS), .DIV_W(DIV_W)) chk_u (.*);

// ===== spp_slave_dev.sv
// Outside serial slave answering the port as master
`timescale 1ns/1ns
module spp_slave_dev (
	// Serial pins
	input wire logic       sclk,
	input wire logic       sel_n,
	input wire logic       mosi,
	output logic           miso,
	// Format and words
	input wire logic       cpol,
	input wire logic       cpha,
	input wire logic [7:0] reply,
	output logic [7:0]     got
);
	logic [7:0] tx_reg;
	logic       k;
	assign k = sclk ^ cpol;
	// Put the next reply bit on the line
	task automatic shift_out();
		miso   = tx_reg[7];
		tx_reg = tx_reg << 1;
	endtask : shift_out
	// Sample on one edge, launch on the other
	task automatic step(input logic lead);
		if (lead ^ cpha)
			got = {got[6:0], mosi};
		else
			shift_out();
	endtask : step
	initial miso = 1'b1;
	// Load reply at select, phase zero shows top bit at once
	always @(negedge sel_n) begin
		tx_reg = reply;
		if (!cpha)
			shift_out();
	end
	// Released line goes to the pull-up level
	always @(posedge sel_n)
		miso = 1'b1;
	always @(posedge k)
		if (!sel_n)
			step(1'b1);
	always @(negedge k)
		if (!sel_n)
			step(1'b0);
endmodule : spp_slave_dev

// ===== tb.sv
// Self-checking bench for the serial port pins
`timescale 1ns/1ns
`define CHK(a, e, m) begin tests_run++; if ((a) !== (e)) begin failures++; \
	$display("MISMATCH %0t %s", $time, m); end end
module tb
	import spp_pkg::*;
;
	logic [CTL_W-1:0] port_control_reg;
	logic [7:0] baud_div, tx_data, rx_data, slave_tx_data, slave_rx_data, reply, got, wd, q;
	logic [3:0] flag_select_en, flag_out_val, flag_out_en, general_flag_out, general_flag_oe_n;
	logic [1:0] boot_mode_pins;
	logic       clock, sys_rst, boot_release, mm_err_clear, start, busy, rx_done, lk, cpol;
	logic       slave_rx_done, multimaster_err, boot_active, serial_clock_in, cpha, dev_miso;
	logic       serial_clock_out, serial_clock_oe_n, slave_select_in, mosi_in, mosi_out;
	logic       mosi_oe_n, miso_in, miso_out, miso_oe_n;
	int         failures, tests_run, fsel, t1, t3;
	spp_port dut_u (.*);
	spp_slave_dev dev_u (.sclk(serial_clock_out), .sel_n(general_flag_out[fsel]),
		.mosi(mosi_out), .miso(dev_miso), .cpol(cpol), .cpha(cpha), .reply(reply), .got(got));
	// Pin wires: port drive when enabled, else far side or pull-up
	assign serial_clock_in = serial_clock_oe_n ? lk : serial_clock_out;
	assign miso_in         = miso_oe_n ? dev_miso : miso_out;
	always #4 clock = ~clock;
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : cyc
	// Verdict and end of run
	task automatic results();
		if (failures == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	// One master word at divider d, t returns cycles to completion
	task automatic xfer(input int d, output int t);
		reply    = $urandom;
		tx_data  = $urandom;
		baud_div = 8'(d);
		cyc(2);
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		for (t = 1; t < 3000 && rx_done !== 1'b1; t++)
			cyc(1);
		`CHK(rx_data, reply, "master word in")
		`CHK(got, tx_data, "master word out")
		if (t >= 3000) begin
			failures++;
			results();
		end
	endtask : xfer
	// Outside master clocks nb bits MSB first on the 6 ns link clock
	task automatic sl_word(input logic [7:0] w, input int nb);
		for (int i = 7; i > 7 - nb; i--) begin
			if (cpha)
				lk = ~lk;
			mosi_in = w[i];
			#3;
			lk = ~lk;
			q = {q[6:0], miso_in};
			#3;
			if (!cpha)
				lk = ~lk;
		end
	endtask : sl_word
	initial begin
		void'($urandom(32'h0344));
		{clock, boot_release, mm_err_clear, start, mosi_in, lk, cpha, fsel} = '0;
		{port_control_reg, baud_div, tx_data, slave_tx_data, reply, flag_select_en} = '0;
		{flag_out_val, flag_out_en, cpol, slave_select_in, sys_rst} = '1;
		failures = 0;
		tests_run = 0;
		// Boot strap reset, then a boot word through flag zero
		boot_mode_pins = BOOT_SPI_MASTER;
		cyc(15);
		`CHK({serial_clock_out, serial_clock_oe_n, mosi_out, mosi_oe_n}, 4'h8, "boot pins")
		cyc(1);
		sys_rst = 1'b0;
		port_control_reg = 16'h0010;
		cyc(4);
		xfer(1, t1);
		`CHK(boot_active, 1'b1, "boot held")
		boot_release = 1'b1;
		cyc(1);
		boot_release = 1'b0;
		`CHK(boot_active, 1'b0, "boot released")
		// Plain reset in mid-run
		boot_mode_pins = 2'h0;
		port_control_reg = '0;
		sys_rst = 1'b1;
		cyc(4);
		`CHK({serial_clock_oe_n, mosi_oe_n}, 2'h3, "pins released")
		sys_rst = 1'b0;
		cyc(4);
		// Master words in every format through a random flag
		for (int m = 0; m < 8; m++) begin
			{cpha, cpol} = 2'(m);
			fsel = $urandom_range(3);
			flag_select_en = 4'h1 << fsel;
			port_control_reg = {11'h0, 1'b1, 1'b0, cpha, cpol, 1'b1};
			xfer($urandom_range(3, 1), t1);
			`CHK(general_flag_oe_n[fsel], 1'b0, "flag select")
		end
		xfer(1, t1);
		xfer(3, t3);
		`CHK(t3 - t1, 128, "word time")
		// Another master pulls select low in mid-word
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(12);
		`CHK(general_flag_out[fsel], 1'b0, "select low in word")
		slave_select_in = 1'b0;
		cyc(8);
		`CHK({multimaster_err, busy}, 2'h2, "multimaster abort")
		slave_select_in = 1'b1;
		cyc(4);
		mm_err_clear = 1'b1;
		cyc(1);
		mm_err_clear = 1'b0;
		`CHK(multimaster_err, 1'b0, "error cleared")
		// Slave words: stray clocks, a partial word, then a whole one
		for (int m = 0; m < 4; m++) begin
			{cpha, cpol} = 2'(m);
			port_control_reg = {10'h0, m == 2, 1'b1, m[0], cpha, cpol, 1'b0};
			lk = cpol;
			slave_tx_data = $urandom;
			wd = $urandom;
			cyc(4);
			sl_word(8'h5a, 8);
			slave_select_in = 1'b0;
			cyc(5);
			sl_word(~wd, 3);
			slave_select_in = 1'b1;
			cyc(10);
			slave_select_in = 1'b0;
			cyc(5);
			sl_word(wd, 8);
			for (t1 = 0; t1 < 20 && slave_rx_done !== 1'b1; t1++)
				cyc(1);
			`CHK(slave_rx_data, wd, "slave word in")
			`CHK(q, m == 2 ? 8'hff : slave_tx_data, "slave word out")
			slave_select_in = 1'b1;
			if (t1 >= 20) begin
				failures++;
				results();
			end
		end
		results();
	end
endmodule : tb
